/* bench/csot_core_model.sv */
`default_nettype none
module csot_core_model
  import csot_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Reset and events
  output logic o_wake_pin,
  output logic o_wake_cmp,
  output logic o_soft_rst,
  output logic o_watchdog_clear_op_op,
  output logic o_sleep_op,
  output logic o_wdt_timeout,
  output logic o_opt_load,
  output logic [7:0] o_w_data,
  // File access
  output logic o_wr_en,
  output logic [4:0] o_wr_addr,
  output logic [7:0] o_wr_data,
  output logic o_rd_en,
  output logic [4:0] o_rd_addr,
  // ALU
  output logic o_alu_go,
  output var csot_op_e o_alu_op,
  output logic [7:0] o_alu_a,
  output logic [7:0] o_alu_b,
  // Pin direction
  output logic [3:0] o_dir
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {o_wake_pin, o_wake_cmp, o_soft_rst, o_watchdog_clear_op_op, o_sleep_op} = '0;
    {o_wdt_timeout, o_opt_load, o_wr_en, o_rd_en, o_alu_go} = '0;
    {o_w_data, o_wr_addr, o_wr_data, o_rd_addr, o_alu_a, o_alu_b} = '0;
    o_alu_op = CSOT_OP_NONE;
    o_dir = 4'hF;
  end

  // Ordinary code leaves the reserved bit and a calibrated trim alone; the bench breaks that only on purpose
  task automatic issue(input logic [9:0] ev, input logic [4:0] adr, input logic [7:0] d,
                       input csot_op_e op, input logic [7:0] a, input logic [7:0] b);
    @(posedge i_clk);
    #1;
    {o_wake_pin, o_wake_cmp, o_soft_rst, o_watchdog_clear_op_op, o_sleep_op} = ev[9:5];
    {o_wdt_timeout, o_opt_load, o_wr_en, o_rd_en, o_alu_go} = ev[4:0];
    o_w_data = d;
    o_wr_data = d;
    o_wr_addr = adr;
    o_rd_addr = adr;
    o_alu_op = op;
    o_alu_a = a;
    o_alu_b = b;
    @(posedge i_clk);
    #1;
    {o_wake_pin, o_wake_cmp, o_soft_rst, o_watchdog_clear_op_op, o_sleep_op} = '0;
    {o_wdt_timeout, o_opt_load, o_wr_en, o_rd_en, o_alu_go} = '0;
    // Released data, address and operand fields turn over so a stale value cannot pass for a held one
    o_w_data = ~d;
    o_wr_data = ~d;
    o_wr_addr = ~adr;
    o_rd_addr = ~adr;
    o_alu_op = CSOT_OP_NONE;
    o_alu_a = ~a;
    o_alu_b = ~b;
  endtask

  task automatic set_dir(input logic [3:0] d);
    @(posedge i_clk);
    #1;
    o_dir = d;
  endtask
endmodule
`default_nettype wire

/* bench/tb.sv */
`default_nettype none
module tb
  import csot_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] EV_PIN = 10'h200, EV_CMP = 10'h100, EV_SOFT = 10'h080, EV_CLR = 10'h040;
  localparam logic [9:0] EV_SLEEP = 10'h020, EV_TO = 10'h010, EV_OPT = 10'h008, EV_WR = 10'h004;
  localparam logic [9:0] EV_RD = 10'h002, EV_GO = 10'h001;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic wpin, wcmp, srst, clr, slp, wto, optl, wr, rd, go;
  logic [7:0] wd, wdat, aa, bb, rdd, ar, st;
  logic [4:0] wadr, radr;
  logic [3:0] dir, tdiv, wdiv, wake_en, pull_en, eff;
  logic [6:0] trim;
  logic hit, qco, src, edg, asg;
  csot_op_e aop;
  wire logic [7:0] tim_v = {1'b0, src, edg, asg, tdiv};
  wire logic [7:0] div_v = {tdiv, wdiv};
  wire logic [7:0] pin_v = {wake_en, pull_en};
  int fail_count = 0;
  int n_checks = 0;

  always #20 clk = ~clk;

  csot_core_model cm (.i_clk(clk), .o_wake_pin(wpin), .o_wake_cmp(wcmp), .o_soft_rst(srst), .o_watchdog_clear_op_op(clr),
    .o_sleep_op(slp), .o_wdt_timeout(wto), .o_opt_load(optl), .o_w_data(wd), .o_wr_en(wr), .o_wr_addr(wadr),
    .o_wr_data(wdat), .o_rd_en(rd), .o_rd_addr(radr), .o_alu_go(go), .o_alu_op(aop), .o_alu_a(aa),
    .o_alu_b(bb), .o_dir(dir));

  csot_core_regs dut (.i_clk(clk), .i_rstn(rstn), .i_soft_rst(srst), .i_wake_pin(wpin), .i_wake_cmp(wcmp),
    .i_wdt_timeout(wto), .i_watchdog_clear_op_op(clr), .i_sleep_op(slp), .i_opt_load(optl), .i_w_data(wd), .i_wr_en(wr),
    .i_wr_addr(wadr), .i_wr_data(wdat), .i_rd_en(rd), .i_rd_addr(radr), .o_rd_data(rdd), .o_rd_hit(hit),
    .i_alu_go(go), .i_alu_op(aop), .i_alu_a(aa), .i_alu_b(bb), .o_alu_result(ar), .o_status(st), .o_trim(trim),
    .o_quarter_clock_out(qco), .i_dir(dir), .o_timer_source_sel(src), .o_timer_edge_sel(edg),
    .o_prescaler_assign(asg), .o_tmr_div_log2(tdiv), .o_wdt_div_log2(wdiv), .o_pin_wake_en(wake_en),
    .o_pullup_en(pull_en), .o_eff_dir(eff));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic cmd(input logic [9:0] ev, input logic [4:0] adr, input logic [7:0] d);
    cm.issue(ev, adr, d, CSOT_OP_NONE, 8'h00, 8'h00);
  endtask

  task automatic rd_chk(input logic [4:0] adr, input logic [7:0] exp, input logic h);
    cmd(EV_RD, adr, 8'h00);
    chk("read data", exp, rdd);
    chk("read hit", {7'h0, h}, {7'h0, hit});
  endtask

  task automatic alu(input csot_op_e op, input logic [7:0] a, input logic [7:0] b, input logic [7:0] res,
                     input logic [2:0] flg, input logic [2:0] msk);
    cm.issue(EV_GO, 5'h00, 8'h00, op, a, b);
    chk("alu result", res, ar);
    chk("flags", {5'h0, flg & msk}, {5'h0, st[2:0] & msk});
  endtask

  task automatic s_reset;
    @(posedge clk);
    #1;
    rstn = 1'b0;
    repeat (20) @(posedge clk);
    #1;
    rstn = 1'b1;
    chk("status", 8'h18, st);
    chk("trim", 8'hFE, {trim, qco});
    chk("timer cfg", 8'h78, tim_v);
    chk("pins", 8'h00, pin_v);
    rd_chk(ADDR_STATUS, 8'h18, 1'b1);
  endtask

  task automatic s_option;
    cmd(EV_OPT, 5'h00, 8'h00);
    chk("pins", 8'hBB, pin_v);
    chk("timer cfg", 8'h01, tim_v);
    for (int a = 0; a < 32; a++) begin
      if (a != 3 && a != 5) begin
        rd_chk(5'(a), 8'h00, 1'b0);
      end
    end
    for (int r = 0; r < 8; r++) begin
      cmd(EV_OPT, 5'h00, {5'h1F, 3'(r)});
      chk("dividers", {4'(r + 1), 4'(r)}, div_v);
    end
    cm.set_dir(4'h9);
    cmd(EV_OPT, 5'h00, 8'h20);
    chk("pins", 8'h99, pin_v);
    chk("direction", 8'h0D, {4'h0, eff});
    cmd(EV_OPT, 5'h00, 8'h00);
    chk("direction", 8'h09, {4'h0, eff});
    cm.set_dir(4'hF);
  endtask

  task automatic s_events;
    cmd(EV_SLEEP, 5'h00, 8'h00);
    chk("to pd", 8'h10, st & 8'h18);
    cmd(EV_CLR, 5'h00, 8'h00);
    chk("to pd", 8'h18, st & 8'h18);
    cmd(EV_TO, 5'h00, 8'h00);
    chk("to pd", 8'h08, st & 8'h18);
    cmd(EV_SLEEP | EV_TO, 5'h00, 8'h00);
    chk("to pd", 8'h00, st & 8'h18);
    cmd(EV_CLR, 5'h00, 8'h00);
    cmd(EV_WR, ADDR_STATUS, 8'hE7);
    chk("status", 8'hFF, st);
    cmd(EV_SOFT | EV_PIN, 5'h00, 8'h00);
    chk("status", 8'h9F, st);
    cmd(EV_SOFT | EV_CMP, 5'h00, 8'h00);
    chk("status", 8'h5F, st);
    cmd(EV_WR, ADDR_TRIM, 8'h00);
    cmd(EV_OPT, 5'h00, 8'h00);
    cmd(EV_SOFT, 5'h00, 8'h00);
    chk("status", 8'h1F, st);
    chk("trim", 8'hFE, {trim, qco});
    chk("timer cfg", 8'h78, tim_v);
  endtask

  task automatic s_alu;
    alu(CSOT_OP_ADD, 8'h0F, 8'h01, 8'h10, 3'b010, 3'b111);
    alu(CSOT_OP_ADD, 8'hFF, 8'h01, 8'h00, 3'b111, 3'b111);
    alu(CSOT_OP_ADD, 8'h08, 8'h07, 8'h0F, 3'b000, 3'b111);
    alu(CSOT_OP_SUB, 8'h01, 8'h10, 8'h0F, 3'b001, 3'b111);
    alu(CSOT_OP_SUB, 8'h10, 8'h10, 8'h00, 3'b111, 3'b111);
    alu(CSOT_OP_SUB, 8'h02, 8'h01, 8'hFF, 3'b000, 3'b111);
    alu(CSOT_OP_ROTR, 8'h01, 8'h00, 8'h00, 3'b001, 3'b001);
    alu(CSOT_OP_ROTL, 8'h80, 8'h00, 8'h01, 3'b001, 3'b001);
    alu(CSOT_OP_ROTL, 8'h01, 8'h00, 8'h03, 3'b000, 3'b001);
    alu(CSOT_OP_LOGIC, 8'h00, 8'h00, 8'h00, 3'b100, 3'b100);
    alu(CSOT_OP_LOGIC, 8'h5A, 8'h00, 8'h5A, 3'b000, 3'b100);
  endtask

  task automatic s_block;
    cm.issue(EV_WR | EV_GO, ADDR_STATUS, 8'h00, CSOT_OP_ADD, 8'hFF, 8'h01);
    chk("status", 8'h1F, st);
    cmd(EV_WR, ADDR_STATUS, 8'h02);
    chk("status", 8'h1A, st);
    cm.issue(EV_WR | EV_GO, ADDR_STATUS, 8'h05, CSOT_OP_ROTL, 8'h80, 8'h00);
    chk("status", 8'h1B, st);
  endtask

  task automatic s_trim;
    cmd(EV_WR, ADDR_TRIM, 8'h55);
    chk("trim", 8'h55, {trim, qco});
    rd_chk(ADDR_TRIM, 8'h55, 1'b1);
  endtask

  // A stuck sequence still ends in the one report
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    wrap_up();
  end

  initial begin
    s_reset();
    s_option();
    s_events();
    s_alu();
    s_block();
    s_trim();
    s_reset();
    wrap_up();
  end
endmodule
`default_nettype wire

/* design/csot_alu_flags.sv */
`default_nettype none
module csot_alu_flags
  import csot_pkg::*;
(
  csot_flag_if.alu f
);
  // Same adder serves add and subtract, so nibble and byte carries stay consistent
  function automatic logic [8:0] add_c(input logic [7:0] x, input logic [7:0] y, input logic ci);
    add_c = {1'b0, x} + {1'b0, y} + {8'h00, ci};
  endfunction

  logic [8:0] sum_add;
  logic [8:0] sum_sub;
  logic [8:0] nib_add;
  logic [8:0] nib_sub;

  assign sum_add = add_c(f.a, f.b, 1'b0);
  assign sum_sub = add_c(f.b, ~f.a, 1'b1);
  assign nib_add = add_c({4'h0, f.a[3:0]}, {4'h0, f.b[3:0]}, 1'b0);
  assign nib_sub = add_c({4'h0, f.b[3:0]}, {4'h0, ~f.a[3:0]}, 1'b1);

  always_comb begin
    f.result = 8'h00;
    f.dc = 1'b0;
    f.c = 1'b0;
    f.upd_z = 1'b0;
    f.upd_dc = 1'b0;
    f.upd_c = 1'b0;
    unique case (f.op)
      CSOT_OP_NONE: begin
        f.result = f.a;
      end
      CSOT_OP_ADD: begin
        f.result = sum_add[7:0];
        f.dc = nib_add[4];
        f.c = sum_add[8];
        {f.upd_z, f.upd_dc, f.upd_c} = 3'b111;
      end
      CSOT_OP_SUB: begin
        // Operand b minus a; carries read as inverted borrows
        f.result = sum_sub[7:0];
        f.dc = nib_sub[4];
        f.c = sum_sub[8];
        {f.upd_z, f.upd_dc, f.upd_c} = 3'b111;
      end
      CSOT_OP_ROTR: begin
        f.result = {f.cin, f.a[7:1]};
        f.c = f.a[0];
        f.upd_c = 1'b1;
      end
      CSOT_OP_ROTL: begin
        f.result = {f.a[6:0], f.cin};
        f.c = f.a[7];
        f.upd_c = 1'b1;
      end
      CSOT_OP_LOGIC: begin
        f.result = f.a;
        f.upd_z = 1'b1;
      end
      default: begin
        f.result = f.a;
      end
    endcase
  end

  assign f.z = (f.result == 8'h00);
endmodule
`default_nettype wire

/* design/csot_core_regs.sv */
`default_nettype none
module csot_core_regs
  import csot_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Non-power-on reset and its cause
  input wire logic i_soft_rst,
  input wire logic i_wake_pin,
  input wire logic i_wake_cmp,
  input wire logic i_wdt_timeout,
  // Special instructions
  input wire logic i_watchdog_clear_op_op,
  input wire logic i_sleep_op,
  input wire logic i_opt_load,
  input wire logic [7:0] i_w_data,
  // File register access
  input wire logic i_wr_en,
  input wire logic [4:0] i_wr_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_rd_en,
  input wire logic [4:0] i_rd_addr,
  output logic [7:0] o_rd_data,
  output logic o_rd_hit,
  // ALU operation
  input wire logic i_alu_go,
  input wire csot_op_e i_alu_op,
  input wire logic [7:0] i_alu_a,
  input wire logic [7:0] i_alu_b,
  output logic [7:0] o_alu_result,
  // Register contents
  output logic [7:0] o_status,
  output logic [6:0] o_trim,
  output logic o_quarter_clock_out,
  // Timer and pin configuration
  input wire logic [3:0] i_dir,
  output logic o_timer_source_sel,
  output logic o_timer_edge_sel,
  output logic o_prescaler_assign,
  output logic [3:0] o_tmr_div_log2,
  output logic [3:0] o_wdt_div_log2,
  output logic [3:0] o_pin_wake_en,
  output logic [3:0] o_pullup_en,
  output logic [3:0] o_eff_dir
);
  logic [7:0] status;
  logic [7:0] option;
  logic [7:0] trim;
  logic [7:0] next_status;
  logic [7:0] next_option;
  logic [7:0] next_trim;
  logic [7:0] rd_mux;
  logic rd_is_status;
  logic rd_is_trim;
  logic wr_status;
  logic wr_trim;
  logic alu_flags_hit;

  csot_flag_if flg ();

  csot_alu_flags u_alu (
    .f(flg.alu)
  );

  assign flg.op = i_alu_go ? i_alu_op : CSOT_OP_NONE;
  assign flg.a = i_alu_a;
  assign flg.b = i_alu_b;
  assign flg.cin = status[ST_CARRY];

  csot_pin_ctl u_pins (
    .i_option(option),
    .i_dir(i_dir),
    .o_pin_wake_en(o_pin_wake_en),
    .o_pullup_en(o_pullup_en),
    .o_eff_dir(o_eff_dir),
    .o_tmr_div_log2(o_tmr_div_log2),
    .o_wdt_div_log2(o_wdt_div_log2)
  );

  assign wr_status = i_wr_en && (i_wr_addr == ADDR_STATUS);
  assign wr_trim = i_wr_en && (i_wr_addr == ADDR_TRIM);
  assign alu_flags_hit = flg.upd_z | flg.upd_dc | flg.upd_c;
  assign rd_is_status = (i_rd_addr == ADDR_STATUS);
  assign rd_is_trim = (i_rd_addr == ADDR_TRIM);
  // The configuration register has no read path at all
  assign rd_mux = rd_is_status ? status : (rd_is_trim ? trim : 8'h00);

  always_comb begin
    next_status = status;
    if (wr_status) begin
      next_status[ST_PIN_WAKE] = i_wr_data[ST_PIN_WAKE];
      next_status[ST_CMP_WAKE] = i_wr_data[ST_CMP_WAKE];
      next_status[ST_RESERVED] = i_wr_data[ST_RESERVED];
      // Writes to all three ALU flags are dropped while an op in the same cycle updates any flag
      if (!alu_flags_hit) begin
        next_status[ST_ZERO:ST_CARRY] = i_wr_data[ST_ZERO:ST_CARRY];
      end
    end
    if (flg.upd_z) begin
      next_status[ST_ZERO] = flg.z;
    end
    if (flg.upd_dc) begin
      next_status[ST_DIGIT_CARRY] = flg.dc;
    end
    if (flg.upd_c) begin
      next_status[ST_CARRY] = flg.c;
    end
    // Timeout and power-down change only by events, never by writes
    if (i_watchdog_clear_op_op) begin
      next_status[ST_TIMEOUT] = 1'b1;
      next_status[ST_POWERDOWN] = 1'b1;
    end
    if (i_sleep_op) begin
      next_status[ST_TIMEOUT] = 1'b1;
      next_status[ST_POWERDOWN] = 1'b0;
    end
    if (i_wdt_timeout) begin
      next_status[ST_TIMEOUT] = 1'b0;
    end
    if (i_soft_rst) begin
      next_status[ST_PIN_WAKE] = i_wake_pin;
      next_status[ST_CMP_WAKE] = i_wake_cmp;
      next_status[ST_RESERVED] = 1'b0;
    end
  end

  always_comb begin
    next_option = option;
    if (i_opt_load) begin
      next_option = i_w_data;
    end
    if (i_soft_rst) begin
      next_option = OPTION_RST;
    end
  end

  always_comb begin
    next_trim = trim;
    if (wr_trim) begin
      next_trim = i_wr_data;
    end
    if (i_soft_rst) begin
      next_trim = TRIM_RST;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      status <= STATUS_POR;
      option <= OPTION_RST;
      trim <= TRIM_RST;
    end else begin
      status <= next_status;
      option <= next_option;
      trim <= next_trim;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rd_data <= 8'h00;
      o_rd_hit <= 1'b0;
    end else if (i_rd_en) begin
      o_rd_data <= rd_mux;
      o_rd_hit <= rd_is_status | rd_is_trim;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_alu_result <= 8'h00;
    end else if (i_alu_go) begin
      o_alu_result <= flg.result;
    end
  end

  assign o_status = status;
  assign o_trim = trim[7:1];
  assign o_quarter_clock_out = trim[0];
  assign o_timer_source_sel = option[OPT_TIMER_SRC];
  assign o_timer_edge_sel = option[OPT_TIMER_EDGE];
  assign o_prescaler_assign = option[OPT_PRESCALE_ASSIGN];

  // Reference arithmetic for the checks below
  logic [8:0] chk_add;
  logic [4:0] chk_nib_sub;
  logic [4:0] chk_nib_add;
  logic [8:0] chk_sub;
  assign chk_add = {1'b0, i_alu_a} + {1'b0, i_alu_b};
  assign chk_nib_sub = {1'b0, i_alu_b[3:0]} + {1'b0, ~i_alu_a[3:0]} + 5'h01;
  assign chk_nib_add = {1'b0, i_alu_a[3:0]} + {1'b0, i_alu_b[3:0]};
  assign chk_sub = {1'b0, i_alu_b} + {1'b0, ~i_alu_a} + 9'h001;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  a_sleep_clears_pd: assert property (
    i_sleep_op && !i_wdt_timeout |=> !status[ST_POWERDOWN] && status[ST_TIMEOUT])
    else $error("sleep did not clear power-down or set timeout");

  a_watchdog_clear_op_sets_flags: assert property (
    i_watchdog_clear_op_op && !i_sleep_op && !i_wdt_timeout |=> status[ST_TIMEOUT] && status[ST_POWERDOWN])
    else $error("watchdog clear did not set timeout and power-down");

  a_timeout_clears_to: assert property (
    i_wdt_timeout |=> !status[ST_TIMEOUT])
    else $error("watchdog timeout left timeout flag set");

  a_wake_cause_flags: assert property (
    i_soft_rst |=> status[ST_PIN_WAKE] == $past(i_wake_pin) && status[ST_CMP_WAKE] == $past(i_wake_cmp)
      && !status[ST_RESERVED])
    else $error("wake flags do not match reset cause");

  a_to_pd_readonly: assert property (
    wr_status && !i_sleep_op && !i_watchdog_clear_op_op && !i_wdt_timeout
      |=> status[ST_TIMEOUT:ST_POWERDOWN] == $past(status[ST_TIMEOUT:ST_POWERDOWN]))
    else $error("status write changed timeout or power-down");

  a_opt_load_copy: assert property (
    i_opt_load && !i_soft_rst |=> option == $past(i_w_data))
    else $error("configuration load did not copy working data");

  a_soft_rst_option: assert property (
    i_soft_rst |=> option == OPTION_RST && trim == TRIM_RST)
    else $error("reset did not restore configuration and trim");

  a_add_flags: assert property (
    i_alu_go && i_alu_op == CSOT_OP_ADD
      |=> status[ST_CARRY] == $past(chk_add[8]) && o_alu_result == $past(chk_add[7:0])
        && status[ST_ZERO] == ($past(chk_add[7:0]) == 8'h00))
    else $error("add result or carry wrong");

  a_sub_digit_carry: assert property (
    i_alu_go && i_alu_op == CSOT_OP_SUB |=> status[ST_DIGIT_CARRY] == $past(chk_nib_sub[4]))
    else $error("subtract digit carry wrong");

  a_rotate_carry: assert property (
    i_alu_go && i_alu_op == CSOT_OP_ROTL |=> status[ST_CARRY] == $past(i_alu_a[7])
      ##1 (status[ST_CARRY] == $past(status[ST_CARRY]) || $past(i_alu_go) || $past(wr_status)))
    else $error("rotate carry wrong");

  a_flag_write_block: assert property (
    wr_status && i_alu_go && i_alu_op == CSOT_OP_ADD |=> status[ST_CARRY] == $past(chk_add[8]))
    else $error("status write overrode computed carry");

  a_dir_override: assert property (
    ((o_pin_wake_en | o_pullup_en) & ~i_dir) == 4'h0)
    else $error("output pin has wake or pull-up enabled");

  a_timer_pin_input: assert property (
    option[OPT_TIMER_SRC] |-> o_eff_dir[TIMER_PIN])
    else $error("timer source select did not force pin input");

  a_trim_readback: assert property (
    i_rd_en && rd_is_trim && !wr_trim && !i_soft_rst ##1 !i_wr_en |-> o_rd_data == trim && o_rd_hit)
    else $error("trim readback wrong");

  a_cmp_wake_flag: assert property (
    i_soft_rst |=> status[ST_CMP_WAKE] == $past(i_wake_cmp))
    else $error("comparator wake flag does not match reset cause");

  a_power_on_values: assert property (
    $rose(i_rstn) |-> status == STATUS_POR && option == OPTION_RST && trim == TRIM_RST)
    else $error("register values after power-on reset wrong");

  a_status_write: assert property (
    wr_status && !i_soft_rst && !alu_flags_hit
      |=> status[ST_PIN_WAKE:ST_RESERVED] == $past(i_wr_data[ST_PIN_WAKE:ST_RESERVED])
        && status[ST_ZERO:ST_CARRY] == $past(i_wr_data[ST_ZERO:ST_CARRY]))
    else $error("status write did not land in writable bits");

  a_wake_flags_hold: assert property (
    !wr_status && !i_soft_rst
      |=> status[ST_PIN_WAKE:ST_RESERVED] == $past(status[ST_PIN_WAKE:ST_RESERVED]))
    else $error("wake flags changed without reset or write");

  a_to_rise_cause: assert property (
    $rose(status[ST_TIMEOUT]) |-> $past(i_watchdog_clear_op_op) || $past(i_sleep_op))
    else $error("timeout flag set without watchdog clear or sleep");

  a_pd_fall_cause: assert property (
    $fell(status[ST_POWERDOWN]) |-> $past(i_sleep_op))
    else $error("power-down flag cleared without sleep");

  a_zero_logic: assert property (
    i_alu_go && i_alu_op == CSOT_OP_LOGIC |=> status[ST_ZERO] == ($past(i_alu_a) == 8'h00))
    else $error("logic zero flag wrong");

  a_add_digit_carry: assert property (
    i_alu_go && i_alu_op == CSOT_OP_ADD |=> status[ST_DIGIT_CARRY] == $past(chk_nib_add[4]))
    else $error("add digit carry wrong");

  a_sub_carry: assert property (
    i_alu_go && i_alu_op == CSOT_OP_SUB
      |=> status[ST_CARRY] == $past(chk_sub[8]) && o_alu_result == $past(chk_sub[7:0]))
    else $error("subtract result or carry wrong");

  a_rotr_carry: assert property (
    i_alu_go && i_alu_op == CSOT_OP_ROTR
      |=> status[ST_CARRY] == $past(i_alu_a[0])
        && o_alu_result == {$past(status[ST_CARRY]), $past(i_alu_a[7:1])})
    else $error("rotate right result or carry wrong");

  a_rotate_write_block: assert property (
    wr_status && i_alu_go && (i_alu_op == CSOT_OP_ROTL || i_alu_op == CSOT_OP_ROTR)
      |=> status[ST_ZERO:ST_DIGIT_CARRY] == $past(status[ST_ZERO:ST_DIGIT_CARRY]))
    else $error("status write changed zero or digit carry during rotate");

  a_trim_write: assert property (
    wr_trim && !i_soft_rst |=> trim == $past(i_wr_data))
    else $error("trim write did not land");

  a_option_hold: assert property (
    !i_opt_load && !i_soft_rst |=> option == $past(option))
    else $error("configuration changed without load or reset");

  a_read_other: assert property (
    i_rd_en && !rd_is_status && !rd_is_trim |=> o_rd_data == 8'h00 && !o_rd_hit)
    else $error("read of unmapped address returned data");

  a_status_readback: assert property (
    i_rd_en && rd_is_status |=> o_rd_data == $past(status) && o_rd_hit)
    else $error("status readback wrong");

  a_wake_enable_low: assert property (
    o_pin_wake_en == (option[OPT_PIN_WAKE_DIS] ? 4'h0 : (WAKE_PIN_MASK & i_dir)))
    else $error("pin wake enables do not follow configuration");

  a_pullup_enable_low: assert property (
    o_pullup_en == (option[OPT_PULLUP_DIS] ? 4'h0 : (WAKE_PIN_MASK & i_dir)))
    else $error("pull-up enables do not follow configuration");

  a_prescale_ratio: assert property (
    o_wdt_div_log2 == {1'b0, option[OPT_RATE_MSB:0]} && o_tmr_div_log2 == o_wdt_div_log2 + 4'h1)
    else $error("prescale ratios do not follow rate field");

  c_sleep_then_clear: cover property (i_sleep_op ##[1:20] i_watchdog_clear_op_op);
  c_pin_wake_reset: cover property (i_soft_rst && i_wake_pin);
  c_add_digit_carry: cover property (i_alu_go && i_alu_op == CSOT_OP_ADD && chk_nib_add[4]);
  c_option_load: cover property (i_opt_load && i_w_data[OPT_TIMER_SRC] == 1'b0);
  c_rotate_write_block: cover property (wr_status && i_alu_go && i_alu_op == CSOT_OP_ROTL);
endmodule
`default_nettype wire

/* design/csot_pin_ctl.sv */
`default_nettype none
module csot_pin_ctl
  import csot_pkg::*;
(
  // Configuration and direction
  input wire logic [7:0] i_option,
  input wire logic [3:0] i_dir,
  // Per-pin enables and effective direction
  output logic [3:0] o_pin_wake_en,
  output logic [3:0] o_pullup_en,
  output logic [3:0] o_eff_dir,
  // Prescaler division as a power of two
  output logic [3:0] o_tmr_div_log2,
  output logic [3:0] o_wdt_div_log2
);
  logic [2:0] rate;
  logic wake_on;
  logic pull_on;

  assign rate = i_option[OPT_RATE_MSB:0];
  assign wake_on = ~i_option[OPT_PIN_WAKE_DIS];
  assign pull_on = ~i_option[OPT_PULLUP_DIS];
  // An output-driven pin can never wake or pull up
  assign o_pin_wake_en = {4{wake_on}} & WAKE_PIN_MASK & i_dir;
  assign o_pullup_en = {4{pull_on}} & WAKE_PIN_MASK & i_dir;
  assign o_eff_dir = i_dir | ({3'b000, i_option[OPT_TIMER_SRC]} << TIMER_PIN);
  assign o_tmr_div_log2 = {1'b0, rate} + 4'h1;
  assign o_wdt_div_log2 = {1'b0, rate};
endmodule
`default_nettype wire

/* design/csot_unused_note.sv */
`default_nettype none
`default_nettype wire

/* pkg/csot_flag_if.sv */
`default_nettype none
interface csot_flag_if;
  import csot_pkg::*;
  csot_op_e op;
  logic [7:0] a;
  logic [7:0] b;
  logic cin;
  logic [7:0] result;
  logic z;
  logic dc;
  logic c;
  logic upd_z;
  logic upd_dc;
  logic upd_c;
  modport alu (input op, input a, input b, input cin,
               output result, output z, output dc, output c, output upd_z, output upd_dc, output upd_c);
  modport core (output op, output a, output b, output cin,
                input result, input z, input dc, input c, input upd_z, input upd_dc, input upd_c);
endinterface
`default_nettype wire

/* pkg/csot_pkg.sv */
`default_nettype none
package csot_pkg;
  localparam logic [4:0] ADDR_STATUS = 5'h03;
  localparam logic [4:0] ADDR_TRIM = 5'h05;
  localparam int ST_PIN_WAKE = 7;
  localparam int ST_CMP_WAKE = 6;
  localparam int ST_RESERVED = 5;
  localparam int ST_TIMEOUT = 4;
  localparam int ST_POWERDOWN = 3;
  localparam int ST_ZERO = 2;
  localparam int ST_DIGIT_CARRY = 1;
  localparam int ST_CARRY = 0;
  localparam int OPT_PIN_WAKE_DIS = 7;
  localparam int OPT_PULLUP_DIS = 6;
  localparam int OPT_TIMER_SRC = 5;
  localparam int OPT_TIMER_EDGE = 4;
  localparam int OPT_PRESCALE_ASSIGN = 3;
  localparam int OPT_RATE_MSB = 2;
  localparam int TIMER_PIN = 2;
  localparam logic [3:0] WAKE_PIN_MASK = 4'hB;
  localparam logic [7:0] STATUS_POR = 8'h18;
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic [7:0] TRIM_RST = 8'hFE;
  localparam logic [3:0] DIR_RST = 4'hF;
  typedef enum logic [2:0] {
    CSOT_OP_NONE = 3'b000,
    CSOT_OP_ADD = 3'b001,
    CSOT_OP_SUB = 3'b010,
    CSOT_OP_ROTR = 3'b011,
    CSOT_OP_ROTL = 3'b100,
    CSOT_OP_LOGIC = 3'b101
  } csot_op_e;
endpackage
`default_nettype wire
